/* File: rtl/clrp_defs.svh */
// Constants for the coherent load register port.
//
// Contract
// - A bus transfer takes two cycles under select, unless the slave stretches it with ready.
// - Write enable when address matches and select, write and enable are all high.
// - Registers are written in the access phase, while enable is high.
// - Read enable when address matches, select high, write and enable low.
// - Selected read data is captured in a flip-flop before returning to the master.
// - Without a read enable the read data output holds its last value.
// - Lower bytes wait in shadow flip-flops; the counter keeps the old committed value.
// - Writing the top byte copies shadow plus that byte into the committed value at once.
// - The committing byte index follows from the load width and the bus width.
// - No shadow or commit staging exists when one access covers the whole width.
// - With equal clocks the load qualifier pulses for one cycle after commit.
// - In periodic mode the counter reloads the committed value whenever it expires.
// - With slower synchronous counter clock the qualifier stays high until a counter edge.
// - A counter-side toggle flips at each counter edge while the qualifier is high.
// - A change of that toggle, seen on the bus side, drops the pending qualifier.
// - The counter takes the committed value on the toggle, then counts normally.
// - Unused addresses and unimplemented bits read as zero.
`ifndef CLRP_DEFS_SVH
`define CLRP_DEFS_SVH

// ---------------------------------------------------------------------------
// Register word addresses (aligned words, byte address bits 1:0 ignored).
// ---------------------------------------------------------------------------
`define CLRP_LOAD_ADDR    8'h00
`define CLRP_CTRL_ADDR    8'h04
`define CLRP_COUNT_ADDR   8'h08
`define CLRP_ADDR_STRIDE  4

// ---------------------------------------------------------------------------
// Control field positions and reset values.
// ---------------------------------------------------------------------------
`define CLRP_CTRL_EN_BIT   0
`define CLRP_CTRL_PER_BIT  1
`define CLRP_CTRL_DOWN_BIT 2
`define CLRP_CTRL_WIDTH    3
`define CLRP_CTRL_RESET    3'h0

`endif

/* File: rtl/clrp_pkg.sv */
// Types shared by the coherent load register port.
package clrp_pkg;
  typedef enum logic [1:0] {CLRP_IDLE, CLRP_SETUP, CLRP_ACCESS} clrp_phase_t;
endpackage

/* File: rtl/clrp_port.sv */
// Register port with coherent byte-wise load value and a counter that uses it.
`include "clrp_defs.svh"

module clrp_port
  import clrp_pkg::*;
#(
  parameter int DATA_W = 8,   // Bus data width: 8, 16 or 32.
  parameter int LOAD_W = 32,  // Load value and counter width, 1 to 32.
  parameter int ADDR_W = 8,
  parameter int CNT_DIV = 1,  // Counter clock enable ratio; 1 means identical clocks.
  parameter bit TOP_AT_3 = 1'b0  // On a 16-bit bus with LOAD_W over 24, TOPBYTE is 3, not 2; the commit lane TOPLANE stays 1.
)(
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // Peripheral bus slave.
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  // Counter status.
  output logic      [LOAD_W-1:0] count_o,
  output logic                   expired_o,
  output logic                   load_request_qualifier_o
);

  // ---------------------------------------------------------------------------
  // Derived geometry.
  // ---------------------------------------------------------------------------
  localparam int LANES   = (LOAD_W + DATA_W - 1) / DATA_W;       // Accesses per value.
  localparam int NBYTES  = (LOAD_W + 7) / 8;
  localparam int BPL     = DATA_W / 8;                           // Bytes per access.
  localparam int TOPBYTE = (DATA_W == 16 && TOP_AT_3 && LOAD_W > 24) ? 3 : ((NBYTES - 1) / BPL) * BPL;
  localparam int TOPLANE = TOPBYTE / BPL;
  localparam bit NO_COHERENCY_NEEDED     = (LANES == 1);                         // no_coherency_needed
  localparam int PW      = LANES * DATA_W;                       // Padded width.
  localparam int SUBW    = (ADDR_W > 2) ? ADDR_W - 2 : 1;

  // Word index of an address; byte lanes inside a word come from low bits.
  function automatic logic [SUBW-1:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = SUBW'(a >> 2);
  endfunction

  // Access number within a word for narrow buses.
  function automatic int lane_of(input logic [ADDR_W-1:0] a);
    lane_of = (DATA_W == 32) ? 0 : int'(a[1:0]) / BPL;
  endfunction

  // ---------------------------------------------------------------------------
  // Address decode and enables.
  // ---------------------------------------------------------------------------
  logic hit_load;
  logic hit_ctrl;
  logic hit_count;
  logic wr_en;
  logic rd_en;
  int   lane;

  assign hit_load  = word_of(paddr_i) == word_of(`CLRP_LOAD_ADDR);
  assign hit_ctrl  = word_of(paddr_i) == word_of(`CLRP_CTRL_ADDR);
  assign hit_count = word_of(paddr_i) == word_of(`CLRP_COUNT_ADDR);
  assign wr_en     = psel_i && pwrite_i && penable_i;
  assign rd_en     = psel_i && !pwrite_i && !penable_i;
  assign lane      = lane_of(paddr_i);
  assign pready_o  = 1'b1;

  // Bus phase tracker, used by the checks.
  clrp_phase_t phase_reg;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_reg <= CLRP_IDLE;
    else if (psel_i && !penable_i)
      phase_reg <= CLRP_SETUP;
    else if (psel_i)
      phase_reg <= CLRP_ACCESS;
    else
      phase_reg <= CLRP_IDLE;
  end

  // ---------------------------------------------------------------------------
  // Control register.
  // ---------------------------------------------------------------------------
  logic [`CLRP_CTRL_WIDTH-1:0] ctrl_reg;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl_reg <= `CLRP_CTRL_RESET;
    else if (wr_en && hit_ctrl && lane == 0)
      ctrl_reg <= pwdata_i[`CLRP_CTRL_WIDTH-1:0];
  end

  // ---------------------------------------------------------------------------
  // Shadow staging and commit.
  // ---------------------------------------------------------------------------
  logic [PW-1:0]     shadow_reg;
  logic [LOAD_W-1:0] committed_load_value_reg;
  logic [PW-1:0]     merged;
  logic              commit;

  // Merge the top access with the staged lower bytes.
  always_comb
  begin
    merged = shadow_reg;
    merged[TOPLANE*DATA_W +: DATA_W] = pwdata_i;
  end

  assign commit = wr_en && hit_load && (NO_COHERENCY_NEEDED || lane == TOPLANE);

  // Lower accesses land in the shadow only; the committed value stays stable.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      shadow_reg <= '0;
    else if (!NO_COHERENCY_NEEDED && wr_en && hit_load && lane < TOPLANE)
      shadow_reg[lane*DATA_W +: DATA_W] <= pwdata_i;
  end

  // Commit copies everything in one cycle.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      committed_load_value_reg <= '0;
    else if (commit)
      committed_load_value_reg <= merged[LOAD_W-1:0];
  end

  // ---------------------------------------------------------------------------
  // Load qualifier and counter-side toggle handshake.
  // ---------------------------------------------------------------------------
  logic [$clog2(CNT_DIV+1)-1:0] div_reg;
  logic cnt_tick;
  logic toggle_reg;
  logic toggle_seen_reg;
  logic toggle_change;
  logic lrq_reg;

  // Counter clock enable: every CNT_DIV bus cycles.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_reg <= '0;
    else if (cnt_tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign cnt_tick = (int'(div_reg) == CNT_DIV - 1);

  // Toggle flips on a counter edge when the qualifier is high.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      toggle_reg <= 1'b0;
    else if (cnt_tick && lrq_reg)
      toggle_reg <= ~toggle_reg;
  end

  // Bus side remembers the toggle to detect a change.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      toggle_seen_reg <= 1'b0;
    else
      toggle_seen_reg <= toggle_reg;
  end
  assign toggle_change = toggle_reg ^ toggle_seen_reg;

  // Qualifier rises after commit and drops on the toggle change; a new commit wins.
  // With identical clocks every edge is a counter edge, so it is a one-cycle pulse.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lrq_reg <= 1'b0;
    else if (commit)
      lrq_reg <= 1'b1;
    else if (CNT_DIV == 1 || toggle_change)
      lrq_reg <= 1'b0;
  end
  assign load_request_qualifier_o = lrq_reg;

  // ---------------------------------------------------------------------------
  // Counter.
  // ---------------------------------------------------------------------------
  logic [LOAD_W-1:0] count_reg;
  logic              at_end;
  logic              expired_reg;
  logic              load_now;

  assign at_end = ctrl_reg[`CLRP_CTRL_DOWN_BIT] ? (count_reg == '0) : (count_reg == '1);

  // Identical clocks load on the qualifier pulse itself; slower ones wait for the toggle.
  assign load_now = (CNT_DIV == 1) ? lrq_reg : toggle_change;

  // Loads on load_now (qualifier or detected toggle), reloads on expiry in periodic mode, else counts.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count_reg <= '0;
    else if (load_now)
      count_reg <= committed_load_value_reg;
    else if (cnt_tick && ctrl_reg[`CLRP_CTRL_EN_BIT])
    begin
      if (at_end && ctrl_reg[`CLRP_CTRL_PER_BIT])
        count_reg <= committed_load_value_reg;
      else if (!at_end && ctrl_reg[`CLRP_CTRL_DOWN_BIT])
        count_reg <= count_reg - 1'b1;
      else if (!at_end)
        count_reg <= count_reg + 1'b1;
    end
  end

  // Expiry flag: high after each enabled counter tick that finds the count at its end with no load_now in that cycle.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      expired_reg <= 1'b0;
    else
      expired_reg <= cnt_tick && ctrl_reg[`CLRP_CTRL_EN_BIT] && at_end && !load_now;
  end
  assign count_o   = count_reg;
  assign expired_o = expired_reg;

  // ---------------------------------------------------------------------------
  // Read path.
  // ---------------------------------------------------------------------------
  logic [PW-1:0]     load_pad;
  logic [PW-1:0]     count_pad;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] prdata_reg;

  assign load_pad  = PW'(committed_load_value_reg);
  assign count_pad = PW'(count_reg);

  // Select read data; unused words, lanes and bits give zero.
  always_comb
  begin
    rd_mux = '0;
    if (lane < LANES)
    begin
      if (hit_load)
        rd_mux = load_pad[lane*DATA_W +: DATA_W];
      else if (hit_count)
        rd_mux = count_pad[lane*DATA_W +: DATA_W];
    end
    if (hit_ctrl && lane == 0)
      rd_mux = DATA_W'(ctrl_reg);
  end

  // Captured on the read enable and held otherwise.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_reg <= '0;
    else if (rd_en)
      prdata_reg <= rd_mux;
  end
  assign prdata_o = prdata_reg;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  access_follows_a: assert property (psel_i && penable_i && phase_reg == CLRP_SETUP |-> pready_o)
    else $error("Access phase after setup not completed.");
  ctrl_write_a: assert property (wr_en && hit_ctrl && lane == 0 |=> ctrl_reg == $past(pwdata_i[`CLRP_CTRL_WIDTH-1:0]))
    else $error("Control write not taken.");
  setup_nowrite_a: assert property (psel_i && !penable_i |=> $stable(committed_load_value_reg))
    else $error("Committed value changed after setup phase.");
  read_capture_a: assert property (rd_en |=> prdata_o == $past(rd_mux))
    else $error("Read data not captured.");
  read_hold_a: assert property (!rd_en |=> $stable(prdata_o))
    else $error("Read data changed without read enable.");
  shadow_stable_a: assert property (wr_en && hit_load && !commit |=> $stable(committed_load_value_reg))
    else $error("Lower byte altered the committed value.");
  commit_take_a: assert property (commit |=> committed_load_value_reg == $past(merged[LOAD_W-1:0]))
    else $error("Commit did not copy the merged value.");
  qual_raise_a: assert property (commit |=> lrq_reg)
    else $error("Qualifier not raised after commit.");
  toggle_flip_a: assert property (cnt_tick && lrq_reg |=> toggle_reg != $past(toggle_reg))
    else $error("Toggle did not flip.");
  qual_drop_a: assert property (toggle_change && !commit |=> !lrq_reg)
    else $error("Qualifier not cleared by toggle change.");
  counter_load_a: assert property (load_now |=> count_reg == $past(committed_load_value_reg))
    else $error("Counter did not load the committed value.");
  period_reload_a: assert property (cnt_tick && ctrl_reg[`CLRP_CTRL_EN_BIT] && ctrl_reg[`CLRP_CTRL_PER_BIT] && at_end
                                    && !load_now |=> count_reg == $past(committed_load_value_reg))
    else $error("Periodic reload missing.");
  qual_bound_a: assert property ($rose(lrq_reg) && CNT_DIV == 1 |=> !lrq_reg)
    else $error("Qualifier held too long.");

  write_commit_c: cover property (commit);
  lower_write_c: cover property (wr_en && hit_load && !commit);
  reload_c: cover property (cnt_tick && ctrl_reg[`CLRP_CTRL_PER_BIT] && at_end);
  read_load_c: cover property (rd_en && hit_load);

endmodule // clrp_port

/* File: tb/clrp_apb_master.sv */
// Bus master model that issues two-phase peripheral bus transfers.
module clrp_apb_master (
  // Clock.
  input  wire logic       sys_clk_i,
  // Bus master side.
  input  wire logic       pready_i,
  output logic            psel_o,
  output logic            penable_o,
  output logic            pwrite_o,
  output logic [7:0]      paddr_o,
  output logic [7:0]      pwdata_o,
  // Set when the slave never completes a transfer.
  output logic            hang_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus is idle at time zero.
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 8'h00;
    hang_o = 1'b0;
  end

  // One transfer: setup cycle, then access held until ready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_i !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 8)
      hang_o <= 1'b1;
    // Released lines show the inverse so stale values never pass.
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule // clrp_apb_master

/* File: tb/coherent_load_register_port_bench.sv */
// Self-checking bench for the coherent load register port.
module coherent_load_register_port_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel, penable, pwrite, pready, expired, lrq, hang;
  logic [7:0]  paddr, pwdata, prdata;
  logic [31:0] count, old, v;
  logic [7:0]  rd_q[$];
  logic [31:0] ld_q[$];
  logic        lrq_prev = 1'b0;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          n_exp, bad;

  // Clock of 100 ns period.
  always #50 sys_clk = ~sys_clk;

  clrp_port #(.DATA_W(8), .LOAD_W(32), .CNT_DIV(1)) clrp_port_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .count_o(count), .expired_o(expired), .load_request_qualifier_o(lrq));

  clrp_apb_master clrp_apb_master_i (
    .sys_clk_i(sys_clk), .pready_i(pready), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .hang_o(hang));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_rd(input logic [7:0] exp, input logic [7:0] got);
    check_val("prdata", {24'h0, exp}, {24'h0, got});
  endtask

  // Writes a load value least significant byte first, checking the staging.
  task automatic load_word(input logic [31:0] val, input logic [31:0] prev);
    for (int i = 0; i < 3; i++)
      clrp_apb_master_i.xfer(1'b1, i[7:0], val[8*i+:8]);
    #10 check_val("count", prev, count);
    check_val("qualifier", 32'h0, {31'h0, lrq});
    ld_q.push_back(val);
    clrp_apb_master_i.xfer(1'b1, 8'h03, val[31:24]);
    for (int n = 0; n < 20 && ld_q.size() > 0; n++)
      @(posedge sys_clk);
    if (ld_q.size() > 0)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // Reads the count word byte by byte.
  task automatic read_word(input logic [31:0] val);
    for (int i = 0; i < 4; i++)
    begin
      rd_q.push_back(val[8*i+:8]);
      clrp_apb_master_i.xfer(1'b0, 8'h08 + i[7:0], 8'h00);
    end
  endtask

  // Watcher: compares read data in the access cycle and the count after a load.
  // It looks at the falling edge, where every registered output has settled.
  always @(negedge sys_clk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0)
      check_rd(rd_q.pop_front(), prdata);
    if (lrq_prev === 1'b1 && lrq === 1'b0 && ld_q.size() > 0)
      check_val("count", ld_q.pop_front(), count);
    lrq_prev = lrq;
  end

  // Watchdog against a hung run.
  initial
  begin
    #400000;
    n_fail++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(40));
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    #10 check_val("count", 32'h0, count);
    check_val("qualifier", 32'h0, {31'h0, lrq});
    check_val("prdata", 32'h0, {24'h0, prdata});
    old = 32'h0;
    for (int k = 0; k < 5; k++)
    begin
      v = (k == 0) ? 32'hFFFF_FFFF : $urandom();
      load_word(v, old);
      read_word(v);
      old = v;
    end
    rd_q.push_front(8'h00);
    clrp_apb_master_i.xfer(1'b0, 8'h0C, 8'h00);
    read_word(old);
    clrp_apb_master_i.xfer(1'b1, 8'h0C, 8'h5A);
    #10 check_val("prdata", {24'h0, old[31:24]}, {24'h0, prdata});
    load_word(32'h0000_0005, old);
    clrp_apb_master_i.xfer(1'b1, 8'h04, 8'h07);
    n_exp = 0;
    bad = 0;
    repeat (60)
    begin
      @(posedge sys_clk);
      n_exp += (expired === 1'b1) ? 1 : 0;
      bad += (count > 32'h5) ? 1 : 0;
    end
    check_val("reload", 32'h1, {31'h0, n_exp >= 2});
    check_val("range", 32'h0, bad);
    check_val("hang", 32'h0, {31'h0, hang});
    report_and_stop();
  end
endmodule // coherent_load_register_port_bench
